// *** verilog/lpd_mode_ctrl.sv ***
// Contract
// - Non-intrusive debug commands are accepted in run and in background.
// - Non-intrusive means memory, memory with status, debug reg, BACKGROUND.
// - CPU register, trace and GO commands execute only in background mode.
// - The wait instruction gates the CPU clock off.
// - Entering wait clears the interrupt mask bit so interrupts are enabled.
// - An interrupt ends wait and restarts the CPU with register stacking.
// - In wait only BACKGROUND and memory-with-status commands are accepted.
// - In wait or stop, memory-with-status commands return an error only.
// - A BACKGROUND command in wait wakes the device into background mode.
// - The stop instruction enters one of two stop modes if stop is enabled.
// - In every stop mode the bus clock and CPU clock are halted.
// - The clock source may keep its reference clocks running in stop.
// - With stop disabled the stop instruction is an illegal-opcode reset.
// - With background disabled its opcode is an illegal-opcode reset.
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`include "lpd_consts.svh"
module lpd_mode_ctrl
  import lpd_pkg::*;
(
  // Clock and reset
  input  wire logic      clk_in,
  input  wire logic      reset_n_in,
  // Mode select pin, sampled after reset release
  input  wire logic      background_mode_select_pin_pin_in,
  // CPU instruction events and interrupt request
  input  wire logic      wait_exec_in,
  input  wire logic      stop_exec_in,
  input  wire logic      background_opcode_exec_in,
  input  wire logic      irq_req_in,
  // Decoded debug command
  input  wire lpd_cmd_s  dbg_cmd_in,
  // Register bus
  input  wire lpd_bus_s  bus_in,
  output logic [7:0]     rdata_out,
  // Mode and clock gating
  output lpd_mode_e      mode_out,
  output lpd_clk_s       clk_ctrl_out,
  // CPU sequencing pulses
  output logic           ccr_i_clear_out,
  output logic           stack_start_out,
  output logic           ilop_reset_out,
  output logic           trace_step_out,
  // Debug command answer
  output lpd_resp_s      dbg_resp_out,
  // Interrupt
  output logic           irq_out
);

  //////////////////////////////////////////////////////////////////////////
  logic        rst_n;
  logic        pin_s;
  lpd_resp_s   gate_resp;
  logic        gate_background_opcode;
  logic        gate_run;
  logic        gate_step;
  lpd_mode_e   mode_q;
  lpd_mode_e   mode_d;
  logic [1:0]  strap_cnt_q;
  logic [1:0]  strap_cnt_d;
  logic        strap_done;
  logic        ccr_d;
  logic        stack_d;
  logic        ilop_d;
  logic [7:0]  ev;
  logic [7:0]  sys_opt_q;
  logic [7:0]  sys_opt_d;
  logic [7:0]  ctrl_q;
  logic [7:0]  ctrl_d;
  logic [7:0]  mask_q;
  logic [7:0]  mask_d;
  logic [7:0]  status_q;
  logic [7:0]  status_d;
  logic [7:0]  rdata_d;
  logic        irq_d;
  lpd_clk_s    clk_d;
  logic        stop_en;
  logic        bdm_en;

  //////////////////////////////////////////////////////////////////////////
  // Reset released through two flops; asserted at once
  lpd_sync2 #(
    .RST_VAL (1'b0)
  ) u_rst_sync (
    .clk_in   (clk_in),
    .rst_n_in (reset_n_in),
    .d_in     (1'b1),
    .q_out    (rst_n)
  );

  // Pin idles high, so reset value matches a released pin
  lpd_sync2 #(
    .RST_VAL (1'b1)
  ) u_pin_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n),
    .d_in     (background_mode_select_pin_pin_in),
    .q_out    (pin_s)
  );

  lpd_cmd_gate u_gate (
    .mode_in     (mode_q),
    .cmd_in      (dbg_cmd_in),
    .resp_out    (gate_resp),
    .to_background_opcode_out (gate_background_opcode),
    .to_run_out  (gate_run),
    .step_out    (gate_step)
  );

  assign stop_en    = sys_opt_q[`LPD_STOP_EN_BIT];
  assign bdm_en     = ctrl_q[`LPD_BDM_EN_BIT];
  assign strap_done = (strap_cnt_q == `LPD_STRAP_CYCLES);

  //////////////////////////////////////////////////////////////////////////
  // Mode sequencing
  always_comb begin
    mode_d      = mode_q;
    strap_cnt_d = strap_cnt_q;
    ccr_d       = 1'b0;
    stack_d     = 1'b0;
    ilop_d      = 1'b0;
    ev          = 8'h00;
    if (!strap_done) begin
      // Pin needs the sync latency before its level can be trusted
      strap_cnt_d = strap_cnt_q + 2'h1;
      if (strap_cnt_d == `LPD_STRAP_CYCLES && !pin_s) begin
        mode_d             = LPD_BACKGROUND_OPCODE;
        ev[`LPD_EV_BACKGROUND_OPCODE]   = 1'b1;
      end
    end else begin
      case (mode_q)
        LPD_RUN: begin
          if (gate_background_opcode) begin
            mode_d           = LPD_BACKGROUND_OPCODE;
            ev[`LPD_EV_BACKGROUND_OPCODE] = 1'b1;
          end else if (wait_exec_in) begin
            mode_d           = LPD_WAIT;
            ccr_d            = 1'b1;
            ev[`LPD_EV_WAIT] = 1'b1;
          end else if (stop_exec_in) begin
            if (stop_en) begin
              mode_d           = LPD_STOP;
              ev[`LPD_EV_STOP] = 1'b1;
            end else begin
              ilop_d           = 1'b1;
              ev[`LPD_EV_ILOP] = 1'b1;
            end
          end else if (background_opcode_exec_in) begin
            if (bdm_en) begin
              mode_d           = LPD_BACKGROUND_OPCODE;
              ev[`LPD_EV_BACKGROUND_OPCODE] = 1'b1;
            end else begin
              ilop_d           = 1'b1;
              ev[`LPD_EV_ILOP] = 1'b1;
            end
          end
        end
        LPD_WAIT: begin
          // Host wake beats a simultaneous interrupt
          if (gate_background_opcode) begin
            mode_d           = LPD_BACKGROUND_OPCODE;
            ev[`LPD_EV_BACKGROUND_OPCODE] = 1'b1;
          end else if (irq_req_in) begin
            mode_d           = LPD_RUN;
            stack_d          = 1'b1;
            ev[`LPD_EV_WAKE] = 1'b1;
          end
        end
        LPD_STOP: begin
          if (irq_req_in) begin
            mode_d           = LPD_RUN;
            stack_d          = 1'b1;
            ev[`LPD_EV_WAKE] = 1'b1;
          end
        end
        LPD_BACKGROUND_OPCODE: begin
          if (gate_run) begin
            mode_d = LPD_RUN;
          end
        end
        default: mode_d = LPD_RUN;
      endcase
    end
    ev[`LPD_EV_REFUSE] = gate_resp.done && !gate_resp.accept;
  end

  // Clock enables follow the next mode so they change with mode_q
  always_comb begin
    clk_d.cpu_clk_en = (mode_d == LPD_RUN) || (mode_d == LPD_BACKGROUND_OPCODE);
    clk_d.bus_clk_en = (mode_d != LPD_STOP);
    clk_d.ref_clk_en = (mode_d != LPD_STOP) ||
                       ctrl_q[`LPD_REF_KEEP_BIT];
    clk_d.stop_deep  = (mode_d == LPD_STOP) &&
                       ctrl_q[`LPD_STOP_DEEP_BIT];
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      mode_q          <= LPD_RUN;
      strap_cnt_q     <= 2'h0;
      ccr_i_clear_out <= 1'b0;
      stack_start_out <= 1'b0;
      ilop_reset_out  <= 1'b0;
      trace_step_out  <= 1'b0;
      dbg_resp_out    <= '0;
      clk_ctrl_out    <= 4'he;
    end else begin
      mode_q          <= mode_d;
      strap_cnt_q     <= strap_cnt_d;
      ccr_i_clear_out <= ccr_d;
      stack_start_out <= stack_d;
      ilop_reset_out  <= ilop_d;
      trace_step_out  <= gate_step;
      dbg_resp_out    <= gate_resp;
      clk_ctrl_out    <= clk_d;
    end
  end

  assign mode_out = mode_q;

  //////////////////////////////////////////////////////////////////////////
  // Registers; a status read clears it, but a new event still lands
  always_comb begin
    sys_opt_d = sys_opt_q;
    ctrl_d    = ctrl_q;
    mask_d    = mask_q;
    status_d  = status_q;
    rdata_d   = 8'h00;
    if (bus_in.we) begin
      case (bus_in.addr)
        `LPD_ADDR_SYS_OPT_ONE:
          sys_opt_d = bus_in.wdata & `LPD_SYS_OPT_ONE_WMSK;
        `LPD_ADDR_CTRL: ctrl_d = bus_in.wdata & `LPD_CTRL_WMSK;
        `LPD_ADDR_MASK: mask_d = bus_in.wdata;
        default: ;
      endcase
    end
    if (bus_in.re) begin
      case (bus_in.addr)
        `LPD_ADDR_SYS_OPT_ONE: rdata_d = sys_opt_q;
        `LPD_ADDR_CTRL:        rdata_d = ctrl_q;
        `LPD_ADDR_MASK:        rdata_d = mask_q;
        `LPD_ADDR_MODE:        rdata_d = {4'h0, mode_q};
        `LPD_ADDR_STATUS: begin
          rdata_d  = status_q;
          status_d = 8'h00;
        end
        default: rdata_d = 8'h00;
      endcase
    end
    status_d = status_d | ev;
    irq_d    = |(status_d & mask_d);
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sys_opt_q <= `LPD_SYS_OPT_ONE_RST;
      ctrl_q    <= `LPD_CTRL_RST;
      mask_q    <= `LPD_MASK_RST;
      status_q  <= 8'h00;
      rdata_out <= 8'h00;
      irq_out   <= 1'b0;
    end else begin
      sys_opt_q <= sys_opt_d;
      ctrl_q    <= ctrl_d;
      mask_q    <= mask_d;
      status_q  <= status_d;
      rdata_out <= rdata_d;
      irq_out   <= irq_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n);

  sequence s_run_wait;
    strap_done && mode_q == LPD_RUN && !gate_background_opcode && wait_exec_in;
  endsequence

  sequence s_wait_irq;
    strap_done && mode_q == LPD_WAIT && !gate_background_opcode && irq_req_in;
  endsequence

  sequence s_run_stop;
    strap_done && mode_q == LPD_RUN && !gate_background_opcode && !wait_exec_in &&
      stop_exec_in;
  endsequence

  AST_WAIT_CLK_OFF: assert property (
    mode_q == LPD_WAIT |-> !clk_ctrl_out.cpu_clk_en)
    else $error("cpu clock running in wait");

  AST_WAIT_CCR: assert property (
    s_run_wait |=> ccr_i_clear_out && mode_q == LPD_WAIT ##1
      !ccr_i_clear_out)
    else $error("interrupt mask not cleared on wait entry");

  AST_WAIT_IRQ: assert property (
    s_wait_irq |=> mode_q == LPD_RUN && stack_start_out &&
      clk_ctrl_out.cpu_clk_en)
    else $error("interrupt did not end wait");

  AST_ACTIVE_ONLY: assert property (
    mode_q != LPD_BACKGROUND_OPCODE && dbg_cmd_in.valid &&
      (dbg_cmd_in.code == LPD_CMD_CPU_REG ||
       dbg_cmd_in.code == LPD_CMD_TRACE ||
       dbg_cmd_in.code == LPD_CMD_GO)
    |=> dbg_resp_out.done && !dbg_resp_out.accept && !trace_step_out)
    else $error("active command taken outside background");

  AST_RUN_NONINTR: assert property (
    mode_q == LPD_RUN && dbg_cmd_in.valid &&
      dbg_cmd_in.code == LPD_CMD_MEM |=> dbg_resp_out.exec)
    else $error("memory command refused in run");

  AST_WAIT_REFUSE: assert property (
    mode_q == LPD_WAIT && dbg_cmd_in.valid &&
      dbg_cmd_in.code != LPD_CMD_BACKGND &&
      dbg_cmd_in.code != LPD_CMD_MEM_STAT
    |=> !dbg_resp_out.accept ##1 $fell(dbg_resp_out.done) ||
      dbg_resp_out.done)
    else $error("command accepted in wait");

  AST_LOWPWR_ERR: assert property (
    (mode_q == LPD_WAIT || mode_q == LPD_STOP) && dbg_cmd_in.valid &&
      dbg_cmd_in.code == LPD_CMD_MEM_STAT
    |=> dbg_resp_out.err_lowpwr && !dbg_resp_out.exec)
    else $error("status access not refused in low power");

  AST_BG_WAKE: assert property (
    strap_done && mode_q == LPD_WAIT && dbg_cmd_in.valid &&
      dbg_cmd_in.code == LPD_CMD_BACKGND
    |=> mode_q == LPD_BACKGROUND_OPCODE && clk_ctrl_out.cpu_clk_en)
    else $error("background command did not wake wait");

  AST_STOP_ENTRY: assert property (
    s_run_stop and stop_en |=> mode_q == LPD_STOP && !ilop_reset_out)
    else $error("stop not entered while enabled");

  AST_STOP_CLKS: assert property (
    mode_q == LPD_STOP |-> !clk_ctrl_out.bus_clk_en &&
      !clk_ctrl_out.cpu_clk_en)
    else $error("clock running in stop");

  AST_STOP_ILOP: assert property (
    s_run_stop and !stop_en |=> ilop_reset_out && mode_q == LPD_RUN)
    else $error("disabled stop not an illegal opcode");

  AST_BACKGROUND_OPCODE_ILOP: assert property (
    strap_done && mode_q == LPD_RUN && !gate_background_opcode && !wait_exec_in &&
      !stop_exec_in && background_opcode_exec_in && !bdm_en
    |=> ilop_reset_out && mode_q == LPD_RUN)
    else $error("disabled background opcode not illegal");

endmodule

// *** shared/lpd_consts.svh ***
`ifndef LPD_CONSTS_SVH
`define LPD_CONSTS_SVH

// Register addresses
`define LPD_ADDR_SYS_OPT_ONE 16'h1802
`define LPD_ADDR_CTRL        16'h1900
`define LPD_ADDR_STATUS      16'h1901
`define LPD_ADDR_MASK        16'h1902
`define LPD_ADDR_MODE        16'h1903

// Field positions
`define LPD_STOP_EN_BIT      5
`define LPD_BDM_EN_BIT       0
`define LPD_REF_KEEP_BIT     1
`define LPD_STOP_DEEP_BIT    2

// Status and mask bit positions
`define LPD_EV_WAIT          0
`define LPD_EV_STOP          1
`define LPD_EV_WAKE          2
`define LPD_EV_BACKGROUND_OPCODE          3
`define LPD_EV_REFUSE        4
`define LPD_EV_ILOP          5

// Reset values and writable bits
`define LPD_SYS_OPT_ONE_RST  8'h00
`define LPD_SYS_OPT_ONE_WMSK 8'he7
`define LPD_CTRL_RST         8'h00
`define LPD_CTRL_WMSK        8'h07
`define LPD_MASK_RST         8'h00

// Cycles after reset before the synchronised mode pin can be sampled;
// one less would still see the synchroniser's reset value
`define LPD_STRAP_CYCLES     2'h3

`endif

// *** shared/lpd_pkg.sv ***
package lpd_pkg;

  typedef enum logic [3:0] {
    LPD_RUN  = 4'b0001,
    LPD_WAIT = 4'b0010,
    LPD_STOP = 4'b0100,
    LPD_BACKGROUND_OPCODE = 4'b1000
  } lpd_mode_e;

  typedef enum logic [2:0] {
    LPD_CMD_MEM      = 3'h0,
    LPD_CMD_MEM_STAT = 3'h1,
    LPD_CMD_DBG_REG  = 3'h2,
    LPD_CMD_BACKGND  = 3'h3,
    LPD_CMD_CPU_REG  = 3'h4,
    LPD_CMD_TRACE    = 3'h5,
    LPD_CMD_GO       = 3'h6
  } lpd_cmd_e;

  typedef struct packed {
    logic     valid;
    lpd_cmd_e code;
  } lpd_cmd_s;

  typedef struct packed {
    logic done;
    logic accept;
    logic exec;
    logic err_lowpwr;
  } lpd_resp_s;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic        re;
  } lpd_bus_s;

  typedef struct packed {
    logic cpu_clk_en;
    logic bus_clk_en;
    logic ref_clk_en;
    logic stop_deep;
  } lpd_clk_s;

endpackage

// *** verilog/lpd_sync2.sv ***
`timescale 1ns/1ps
module lpd_sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // Data
  input  wire logic d_in,
  output logic      q_out
);
  logic meta_q;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= RST_VAL;
      q_out  <= RST_VAL;
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end
endmodule

// *** verilog/lpd_cmd_gate.sv ***
`timescale 1ns/1ps
module lpd_cmd_gate
  import lpd_pkg::*;
(
  // Current mode and command
  input  wire lpd_mode_e mode_in,
  input  wire lpd_cmd_s  cmd_in,
  // Verdict
  output lpd_resp_s      resp_out,
  output logic           to_background_opcode_out,
  output logic           to_run_out,
  output logic           step_out
);
  function automatic logic is_nonintr(input lpd_cmd_e c);
    is_nonintr = (c == LPD_CMD_MEM) || (c == LPD_CMD_MEM_STAT) ||
                 (c == LPD_CMD_DBG_REG) || (c == LPD_CMD_BACKGND);
  endfunction

  always_comb begin
    resp_out    = '0;
    to_background_opcode_out = 1'b0;
    to_run_out  = 1'b0;
    step_out    = 1'b0;
    if (cmd_in.valid) begin
      resp_out.done = 1'b1;
      case (mode_in)
        LPD_RUN: begin
          resp_out.accept = is_nonintr(cmd_in.code);
          resp_out.exec   = resp_out.accept &&
                            (cmd_in.code != LPD_CMD_BACKGND);
          to_background_opcode_out     = (cmd_in.code == LPD_CMD_BACKGND);
        end
        LPD_BACKGROUND_OPCODE: begin
          resp_out.accept = 1'b1;
          resp_out.exec   = (cmd_in.code != LPD_CMD_BACKGND);
          to_run_out      = (cmd_in.code == LPD_CMD_GO);
          step_out        = (cmd_in.code == LPD_CMD_TRACE);
        end
        LPD_WAIT, LPD_STOP: begin
          // Status reads report the low-power state, never touch memory
          if (cmd_in.code == LPD_CMD_MEM_STAT) begin
            resp_out.accept     = 1'b1;
            resp_out.err_lowpwr = 1'b1;
          end else if (cmd_in.code == LPD_CMD_BACKGND &&
                       mode_in == LPD_WAIT) begin
            resp_out.accept = 1'b1;
            to_background_opcode_out     = 1'b1;
          end
        end
        default: resp_out.done = 1'b1;
      endcase
    end
  end
endmodule

// *** verification/lpd_dbg_host.sv ***
`timescale 1ns/1ps
module lpd_dbg_host
  import lpd_pkg::*;
(
  // Clock
  input  wire logic      clk_in,
  // Command link
  input  wire lpd_resp_s resp_in,
  output lpd_cmd_s       cmd_out,
  output logic           pin_out
);
  logic pin_q = 1'b1;

  // Pin idles high so the part straps into run mode after reset
  assign pin_out = pin_q;

  initial cmd_out = '0;

  ////////////////////////////////////////////////////////////////////////
  // One command per call; the answer stands one cycle, so take it then
  task automatic send(input lpd_cmd_e code, output lpd_resp_s r);
    @(posedge clk_in);
    cmd_out <= {1'b1, code};
    @(posedge clk_in);
    cmd_out <= '0;
    #1 r = resp_in;
  endtask

  // Level seen by the strap sampler at the next reset release
  task automatic set_pin(input logic v);
    pin_q <= v;
  endtask
endmodule

// *** verification/lpd_mode_ctrl_tb.sv ***
`timescale 1ns/1ps
module lpd_mode_ctrl_tb;
  import lpd_pkg::*;
  logic       clk_in       = 1'b0;
  logic       reset_n_in   = 1'b0;
  logic       wait_exec_in = 1'b0;
  logic       stop_exec_in = 1'b0;
  logic       background_opcode_exec_in = 1'b0;
  logic       irq_req_in   = 1'b0;
  lpd_bus_s   bus_in       = '0;
  logic       pin;
  lpd_cmd_s   dbg_cmd;
  lpd_resp_s  dbg_resp;
  lpd_resp_s  resp_q;
  lpd_mode_e  mode_out;
  lpd_clk_s   clk_ctrl_out;
  logic [7:0] rdata_out;
  logic       ccr_i_clear_out;
  logic       stack_start_out;
  logic       ilop_reset_out;
  logic       trace_step_out;
  logic       irq_out;
  int         fails        = 0;
  int         n_compared   = 0;

  always #12.5 clk_in = ~clk_in;

  lpd_mode_ctrl lpd_mode_ctrl_inst (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .background_mode_select_pin_pin_in(pin),
    .wait_exec_in(wait_exec_in), .stop_exec_in(stop_exec_in),
    .background_opcode_exec_in(background_opcode_exec_in), .irq_req_in(irq_req_in),
    .dbg_cmd_in(dbg_cmd), .bus_in(bus_in), .rdata_out(rdata_out),
    .mode_out(mode_out), .clk_ctrl_out(clk_ctrl_out),
    .ccr_i_clear_out(ccr_i_clear_out), .stack_start_out(stack_start_out),
    .ilop_reset_out(ilop_reset_out), .trace_step_out(trace_step_out),
    .dbg_resp_out(dbg_resp), .irq_out(irq_out)
  );

  lpd_dbg_host lpd_dbg_host_inst (
    .clk_in(clk_in), .resp_in(dbg_resp), .cmd_out(dbg_cmd), .pin_out(pin)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_in);
    bus_in <= {a, d, 1'b1, 1'b0};
    @(posedge clk_in);
    bus_in <= '0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    bus_in <= {a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_in);
    bus_in <= '0;
    #1 chk(rdata_out, exp);
  endtask

  // Order of bits: wait, stop, background opcode, interrupt request
  task automatic cpu(input logic [3:0] v);
    @(posedge clk_in);
    {wait_exec_in, stop_exec_in, background_opcode_exec_in, irq_req_in} <= v;
    @(posedge clk_in);
    {wait_exec_in, stop_exec_in, background_opcode_exec_in, irq_req_in} <= 4'h0;
    #1;
  endtask

  // Expected pair is done and accept
  task automatic cmd(input lpd_cmd_e c, input logic [1:0] exp);
    lpd_dbg_host_inst.send(c, resp_q);
    chk({6'h0, resp_q.done, resp_q.accept}, {6'h0, exp});
  endtask

  task automatic md(input lpd_mode_e m);
    chk({4'h0, mode_out}, {4'h0, m});
  endtask

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Every sequence below is fixed length; this only catches a stuck run
  initial begin
    repeat (5000) @(posedge clk_in);
    fails++;
    end_of_test();
  end

  initial begin
    repeat (8) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (10) @(posedge clk_in);
    // Register map and writable bits
    rdc(16'h1802, 8'h00);
    rdc(16'h1903, 8'h01);
    rdc(16'h1904, 8'h00);
    wr(16'h1802, 8'hff);
    rdc(16'h1802, 8'he7);
    wr(16'h1802, 8'h00);
    wr(16'h1900, 8'hff);
    rdc(16'h1900, 8'h07);
    wr(16'h1900, 8'h00);
    // Commands in run mode
    for (int i = 0; i < 7; i++) begin
      if (i != 3)
        cmd(lpd_cmd_e'(3'(i)), (i < 3) ? 2'b11 : 2'b10);
    end
    cmd(LPD_CMD_BACKGND, 2'b11);
    md(LPD_BACKGROUND_OPCODE);
    rdc(16'h1901, 8'h18);
    // Commands in background mode
    for (int i = 0; i < 5; i++) begin
      cmd(lpd_cmd_e'(3'(i)), 2'b11);
    end
    cmd(LPD_CMD_TRACE, 2'b11);
    chk({7'h0, trace_step_out}, 8'h01);
    cmd(LPD_CMD_GO, 2'b11);
    md(LPD_RUN);
    // Wait entry, restricted commands, interrupt wake
    wr(16'h1902, 8'h01);
    cpu(4'b1000);
    md(LPD_WAIT);
    chk({7'h0, ccr_i_clear_out}, 8'h01);
    chk({7'h0, clk_ctrl_out.cpu_clk_en}, 8'h00);
    for (int i = 0; i < 7; i++) begin
      if (i != 3) cmd(lpd_cmd_e'(3'(i)), (i == 1) ? 2'b11 : 2'b10);
      if (i == 1) chk({6'h0, resp_q.exec, resp_q.err_lowpwr}, 8'h01);
    end
    md(LPD_WAIT);
    chk({7'h0, irq_out}, 8'h01);
    cpu(4'b0001);
    md(LPD_RUN);
    chk({7'h0, stack_start_out}, 8'h01);
    chk({7'h0, clk_ctrl_out.cpu_clk_en}, 8'h01);
    rdc(16'h1901, 8'h15);
    repeat (2) @(posedge clk_in);
    #1 chk({7'h0, irq_out}, 8'h00);
    // Background command wakes from wait
    cpu(4'b1000);
    cmd(LPD_CMD_BACKGND, 2'b11);
    md(LPD_BACKGROUND_OPCODE);
    chk({7'h0, clk_ctrl_out.cpu_clk_en}, 8'h01);
    cmd(LPD_CMD_GO, 2'b11);
    // Opcodes refused while their enable bits are clear
    cpu(4'b0100);
    chk({7'h0, ilop_reset_out}, 8'h01);
    md(LPD_RUN);
    cpu(4'b0010);
    chk({7'h0, ilop_reset_out}, 8'h01);
    md(LPD_RUN);
    wr(16'h1900, 8'h01);
    cpu(4'b0010);
    md(LPD_BACKGROUND_OPCODE);
    cmd(LPD_CMD_GO, 2'b11);
    // Both stop flavours, with and without reference clocks kept
    wr(16'h1802, 8'h20);
    for (int i = 0; i < 2; i++) begin
      wr(16'h1900, (i == 1) ? 8'h06 : 8'h00);
      cpu(4'b0100);
      md(LPD_STOP);
      chk({4'h0, clk_ctrl_out}, (i == 1) ? 8'h03 : 8'h00);
      cmd(LPD_CMD_MEM_STAT, 2'b11);
      chk({6'h0, resp_q.exec, resp_q.err_lowpwr}, 8'h01);
      cpu(4'b0001);
      md(LPD_RUN);
      chk({4'h0, clk_ctrl_out}, 8'h0e);
    end
    // Mid-run reset with the mode pin low straps into background
    @(posedge clk_in);
    reset_n_in <= 1'b0;
    lpd_dbg_host_inst.set_pin(1'b0);
    repeat (4) @(posedge clk_in);
    #1 md(LPD_RUN);
    chk({4'h0, clk_ctrl_out}, 8'h0e);
    @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (10) @(posedge clk_in);
    #1 md(LPD_BACKGROUND_OPCODE);
    rdc(16'h1901, 8'h08);
    cmd(LPD_CMD_GO, 2'b11);
    md(LPD_RUN);
    end_of_test();
  end
endmodule
